// ===== inc/acq_defs.svh
// Constants for the acquisition mode processor.
`ifndef ACQ_DEFS_SVH
`define ACQ_DEFS_SVH
`define SAMPLE_W        12
`define POINTS_W        10
`define COUNT_W         8
`define DIV_W           16
`define FIFO_DEPTH      16
`define MODE_SAMPLE     2'h0
`define MODE_ENVELOPE   2'h1
`define MODE_AVERAGE    2'h2
`define INTERP_PS_DIV   25000
`define CLK_PS          20000
`endif

// ===== inc/acq_pkg.sv
// Types shared by the acquisition mode processor.
package acq_pkg;
  typedef enum logic [1:0] {
    MODE_SAMPLE   = 2'h0,
    MODE_ENVELOPE = 2'h1,
    MODE_AVERAGE  = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_ARMED   = 2'h1,
    ST_CAPTURE = 2'h2,
    ST_STOPPED = 2'h3
  } state_t;

  typedef struct packed {
    logic [9:0]  index;
    logic [11:0] value;
  } point_t;

  typedef struct packed {
    logic        running;
    logic        stopped;
    logic [1:0]  mode;
    logic [7:0]  acq_count;
  } status_t;
endpackage : acq_pkg

// ===== hdl/acq_fifo.sv
// Small valid/ready FIFO for output record points.
`timescale 1ns/1ps
module acq_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              full  = (wp_q[AW] != rp_q[AW]) &&
                            (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire              empty = (wp_q == rp_q);
  wire              push  = in_valid && !full;
  wire              pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_q[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule : acq_fifo

// ===== hdl/acq_mode_proc.sv
// Acquisition mode processor: sample, envelope and average record builder.
`timescale 1ns/1ps
`include "acq_defs.svh"
module acq_mode_proc #(
  parameter int SW  = `SAMPLE_W,
  parameter int PW  = `POINTS_W,
  parameter int CW  = `COUNT_W,
  parameter int DW  = `DIV_W
) (
  input  wire logic          CORE_CLK,
  input  wire logic          SYS_RST,
  input  wire logic          SAMPLE_VALID,
  input  wire logic [SW-1:0] SAMPLE_DATA,
  input  wire logic          TRIGGER,
  input  wire logic [1:0]    MODE_SEL,
  input  wire logic          MODE_LOAD,
  input  wire logic [CW-1:0] ACQ_TARGET,
  input  wire logic [PW-1:0] RECORD_POINTS,
  input  wire logic [DW-1:0] INTERVAL_SAMPLES,
  input  wire logic [31:0]   SCALE_PS_DIV,
  input  wire logic          RUN_STOP_BUTTON,
  input  wire logic          SHIFT_KEY,
  input  wire logic          FORCE_TRIGGER_BUTTON,
  input  wire logic          STOP_AFTER_MANUAL,
  input  wire logic          SETTINGS_CHANGE,
  input  wire logic [31:0]   SAMPLE_RATE,
  output logic               POINT_VALID,
  input  wire logic          POINT_READY,
  output acq_pkg::point_t    POINT_OUT,
  output acq_pkg::status_t   STATUS,
  output logic [31:0]        RATE_STATUS,
  output logic               SINGLE_SEQ,
  output logic               INTERPOLATE
);
  // ------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------
  acq_pkg::mode_t  mode_q;
  acq_pkg::state_t state_q;
  logic            halted_q;
  logic            single_q;
  logic [CW-1:0]   count_q;
  logic [PW-1:0]   point_q;
  logic [DW-1:0]   sub_q;
  logic [SW-1:0]   first_q;
  logic [SW-1:0]   run_mx_q;
  logic [SW-1:0]   run_mn_q;
  logic [PW:0]     emit_q;
  logic            emit_busy_q;

  // Envelope record holds max/min pairs; average holds running sums.
  logic [SW-1:0]    env_max [2**PW];
  logic [SW-1:0]    env_min [2**PW];
  logic [SW+CW-1:0] avg_sum [2**PW];

  wire fifo_ready;
  wire is_sample = (mode_q == acq_pkg::MODE_SAMPLE);
  wire is_env    = (mode_q == acq_pkg::MODE_ENVELOPE);
  wire is_avg    = (mode_q == acq_pkg::MODE_AVERAGE);
  wire capturing = (state_q == acq_pkg::ST_CAPTURE);
  wire start_acq = (state_q == acq_pkg::ST_ARMED) && TRIGGER;
  // An interval is span/points, given here as a sample count per point.
  wire int_end   = SAMPLE_VALID &&
                   (sub_q == INTERVAL_SAMPLES - 1'b1);
  wire first_smp = SAMPLE_VALID && (sub_q == '0);
  wire last_pt   = int_end && (point_q == RECORD_POINTS - 1'b1);
  wire [CW-1:0] count_inc = count_q + 1'b1;
  wire target_hit = (count_inc >= ACQ_TARGET);
  // Accumulating modes never finish on one record.
  wire [CW-1:0] eff_target = (ACQ_TARGET < 2) ?
                             CW'(2) : ACQ_TARGET;
  wire seq_done  = is_sample ? 1'b1
                   : (count_inc >= eff_target);
  wire toggle    = RUN_STOP_BUTTON && !single_q;
  wire major_chg = SETTINGS_CHANGE || MODE_LOAD;
  wire [1:0] next_mode = (MODE_SEL > 2'h2) ? `MODE_SAMPLE : MODE_SEL;

  // ------------------------------------------------------------
  // Mode and stop-after selection
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      mode_q <= acq_pkg::MODE_SAMPLE;
    else if (MODE_LOAD)
      mode_q <= acq_pkg::mode_t'(next_mode);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
      single_q <= 1'b0;
    else if (SHIFT_KEY && FORCE_TRIGGER_BUTTON)
      single_q <= 1'b1;
    else if (STOP_AFTER_MANUAL)
      single_q <= 1'b0;
  end

  // ------------------------------------------------------------
  // Run/stop sequencing
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      state_q  <= acq_pkg::ST_ARMED;
      halted_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        acq_pkg::ST_IDLE:
          state_q <= acq_pkg::ST_ARMED;
        acq_pkg::ST_ARMED:
          if (toggle)
          begin
            state_q  <= acq_pkg::ST_STOPPED;
            halted_q <= 1'b1;
          end
          else if (TRIGGER)
            state_q <= acq_pkg::ST_CAPTURE;
        acq_pkg::ST_CAPTURE:
          // A Run/Stop press outside single sequence aborts the record being captured, except on its last point, which still completes it.
          if (toggle)
          begin
            state_q  <= acq_pkg::ST_STOPPED;
            halted_q <= 1'b1;
          end
          // One trigger fills a whole record in sample mode.
          else if (last_pt)
          begin
            if (single_q && seq_done)
            begin
              state_q  <= acq_pkg::ST_STOPPED;
              halted_q <= 1'b1;
            end
            else
              state_q <= acq_pkg::ST_ARMED;
          end
        acq_pkg::ST_STOPPED:
          if (RUN_STOP_BUTTON)
          begin
            state_q  <= acq_pkg::ST_ARMED;
            halted_q <= 1'b0;
          end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Acquisition counter
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST || major_chg)
      count_q <= '0;
    else if (state_q == acq_pkg::ST_STOPPED && RUN_STOP_BUTTON)
      count_q <= '0;
    else if (capturing && last_pt && count_q != {CW{1'b1}})
      count_q <= count_inc;
  end

  // ------------------------------------------------------------
  // Point forming
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST || start_acq)
    begin
      sub_q   <= '0;
      point_q <= '0;
    end
    else if (capturing && SAMPLE_VALID)
    begin
      sub_q <= int_end ? '0 : sub_q + 1'b1;
      if (int_end)
        point_q <= last_pt ? '0 : point_q + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (capturing && first_smp)
      first_q <= SAMPLE_DATA;
  end

  // Envelope peaks are tracked over every sample of the interval.
  wire [SW-1:0] int_mx = (sub_q == '0 || SAMPLE_DATA > run_mx_q) ?
                         SAMPLE_DATA : run_mx_q;
  wire [SW-1:0] int_mn = (sub_q == '0 || SAMPLE_DATA < run_mn_q) ?
                         SAMPLE_DATA : run_mn_q;

  always_ff @(posedge CORE_CLK)
  begin
    if (capturing && SAMPLE_VALID)
    begin
      run_mx_q <= int_mx;
      run_mn_q <= int_mn;
    end
  end

  // Accumulation happens when the interval closes; later samples dropped.
  wire [SW-1:0]    smp    = (sub_q == '0) ? SAMPLE_DATA : first_q;
  wire [SW-1:0]    old_mx = env_max[point_q];
  wire [SW-1:0]    old_mn = env_min[point_q];
  wire             fresh  = (count_q == '0);
  wire [SW+CW-1:0] old_s  = fresh ? '0 : avg_sum[point_q];

  always_ff @(posedge CORE_CLK)
  begin
    if (capturing && int_end)
    begin
      // Sample mode reuses the max array as its plain record store.
      env_max[point_q] <= is_sample ? smp
                        : (fresh || int_mx > old_mx) ? int_mx
                        : old_mx;
      env_min[point_q] <= (fresh || int_mn < old_mn) ? int_mn
                        : old_mn;
      avg_sum[point_q] <= old_s + (SW+CW)'(smp);
    end
  end

  // ------------------------------------------------------------
  // Record output once the required acquisitions are done
  // ------------------------------------------------------------
  wire            rec_done = capturing && last_pt &&
                             (is_sample || count_inc >= eff_target)
                             && (is_sample || target_hit);
  wire [PW:0]     rec_len  = is_env ? {RECORD_POINTS, 1'b0}
                                    : {1'b0, RECORD_POINTS};
  wire [PW-1:0]   e_idx    = is_env ? emit_q[PW:1] : emit_q[PW-1:0];
  wire [CW-1:0]   div_n    = (count_q == '0) ? CW'(1) : count_q;
  wire [SW+CW-1:0] avg_q   = avg_sum[e_idx] / (SW+CW)'(div_n);
  wire [SW-1:0]   e_val    = is_avg ? avg_q[SW-1:0]
                           : is_env ? (emit_q[0] ? env_min[e_idx]
                                                 : env_max[e_idx])
                           : env_max[e_idx];
  acq_pkg::point_t fifo_in;
  assign fifo_in.index = emit_q[PW-1:0];
  assign fifo_in.value = e_val;

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      emit_busy_q <= 1'b0;
      emit_q      <= '0;
    end
    else if (rec_done)
    begin
      emit_busy_q <= 1'b1;
      emit_q      <= '0;
    end
    else if (emit_busy_q && fifo_ready)
    begin
      emit_q      <= emit_q + 1'b1;
      emit_busy_q <= (emit_q + 1'b1 != rec_len);
    end
  end

  acq_fifo #(
    .WIDTH ($bits(acq_pkg::point_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst       (SYS_RST),
    .in_valid  (emit_busy_q),
    .in_ready  (fifo_ready),
    .in_data   (fifo_in),
    .out_valid (POINT_VALID),
    .out_ready (POINT_READY),
    .out_data  (POINT_OUT)
  );

  // ------------------------------------------------------------
  // Status
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      STATUS      <= '0;
      RATE_STATUS <= '0;
      INTERPOLATE <= 1'b0;
    end
    else
    begin
      STATUS.running   <= !halted_q;
      STATUS.stopped   <= halted_q;
      STATUS.mode      <= mode_q;
      STATUS.acq_count <= halted_q ? count_q : '0;
      RATE_STATUS      <= halted_q ? '0 : SAMPLE_RATE;
      INTERPOLATE      <= (SCALE_PS_DIV < `INTERP_PS_DIV);
    end
  end

  assign SINGLE_SEQ = single_q;
endmodule : acq_mode_proc

// ===== dv/acq_props.sv
// Port checker for the acquisition mode processor.
`timescale 1ns/1ps
module acq_props (
  input wire logic             CORE_CLK,
  input wire logic             SYS_RST,
  input wire logic [1:0]       MODE_SEL,
  input wire logic             MODE_LOAD,
  input wire logic [31:0]      SCALE_PS_DIV,
  input wire logic             RUN_STOP_BUTTON,
  input wire logic             SHIFT_KEY,
  input wire logic             FORCE_TRIGGER_BUTTON,
  input wire logic             STOP_AFTER_MANUAL,
  input wire logic             SETTINGS_CHANGE,
  input wire logic [31:0]      SAMPLE_RATE,
  input wire acq_pkg::status_t STATUS,
  input wire logic [31:0]      RATE_STATUS,
  input wire logic             SINGLE_SEQ,
  input wire logic             INTERPOLATE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence press_s;
    RUN_STOP_BUTTON && !SINGLE_SEQ;
  endsequence
  reset_mode_a: assert property ($fell(SYS_RST) |-> STATUS.mode == 2'h0)
    else $error("mode not sample after reset");
  mode_load_a: assert property (MODE_LOAD |=> ##1 STATUS.mode ==
    (($past(MODE_SEL, 2) == 2'h3) ? 2'h0 : $past(MODE_SEL, 2)))
    else $error("mode status wrong");
  count_clear_a: assert property (SETTINGS_CHANGE || MODE_LOAD |=> ##1
    STATUS.acq_count == 8'h00) else $error("count not cleared");
  rate_run_a: assert property (STATUS.running ##1 STATUS.running |->
    RATE_STATUS == $past(SAMPLE_RATE)) else $error("rate status wrong");
  halt_rate_a: assert property (STATUS.stopped [*2] |->
    RATE_STATUS == 32'h0) else $error("rate shown while stopped");
  halt_press_a: assert property (press_s ##0 STATUS.running |=> ##1
    STATUS.stopped) else $error("press did not halt");
  resume_press_a: assert property (press_s ##0 STATUS.stopped |=> ##1
    !STATUS.stopped) else $error("press did not resume");
  single_set_a: assert property (SHIFT_KEY && FORCE_TRIGGER_BUTTON |=>
    SINGLE_SEQ) else $error("single sequence not set");
  single_hold_a: assert property (SINGLE_SEQ && !STOP_AFTER_MANUAL |=>
    SINGLE_SEQ) else $error("single sequence dropped");
  scale_interp_a: assert property (1'b1 |=> INTERPOLATE ==
    ($past(SCALE_PS_DIV) < 32'h61A8)) else $error("interpolate wrong");
endmodule : acq_props

// ===== dv/acq_source.sv
// Digitizer and trigger model that sends one record per request.
`timescale 1ns/1ps
module acq_source (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [11:0] base,
  input  wire logic [15:0] count,
  output logic             trig,
  output logic             valid,
  output logic      [11:0] data
);
  logic [15:0] left = 16'h0;
  logic [11:0] k    = 12'h0;
  logic        gap  = 1'b0;
  initial {trig, valid, data} = '0;
  // Idle data flips every cycle so a stale value never passes for a sample.
  always @(posedge clk)
  begin
    trig  <= go;
    valid <= 1'b0;
    data  <= ~data;
    gap   <= ~gap;
    if (go)
    begin
      left <= count;
      k    <= 12'h0;
    end
    else if (left != 16'h0 && !(slow && gap))
    begin
      valid <= 1'b1;
      data  <= base + k;
      left  <= left - 16'h1;
      k     <= k + 12'h1;
    end
  end
endmodule : acq_source

// ===== dv/acquisition_mode_processor_tb.sv
// Self-checking testbench for the acquisition mode processor.
`timescale 1ns/1ps
module acquisition_mode_processor_tb;
  logic             clk = 1'b0, rst = 1'b1, go = 1'b0, slow = 1'b0;
  logic             ready = 1'b0, mode_load = 1'b0, trig, s_valid, p_valid;
  logic [11:0]      base = 12'h0, s_data;
  logic [1:0]       mode_sel = 2'h0;
  logic [7:0]       target = 8'h02;
  logic [31:0]      scale = 32'h61A8, rate_st;
  logic [4:0]       btn = 5'h00;
  logic             single, interp;
  acq_pkg::point_t  p_out;
  acq_pkg::status_t status;
  int               mismatches = 0, check_count = 0, timer = 0;
  always #10 clk = ~clk;
  // The far side stalls every other cycle.
  always @(posedge clk) ready <= ~ready;
  acq_source u_src (.clk(clk), .go(go), .slow(slow), .base(base),
    .count(16'h000C), .trig(trig), .valid(s_valid), .data(s_data));
  acq_mode_proc u_dut (.CORE_CLK(clk), .SYS_RST(rst), .SAMPLE_VALID(s_valid),
    .SAMPLE_DATA(s_data), .TRIGGER(trig), .MODE_SEL(mode_sel),
    .MODE_LOAD(mode_load), .ACQ_TARGET(target), .RECORD_POINTS(10'h004),
    .INTERVAL_SAMPLES(16'h0003), .SCALE_PS_DIV(scale),
    .RUN_STOP_BUTTON(btn[0]), .SHIFT_KEY(btn[1]),
    .FORCE_TRIGGER_BUTTON(btn[2]), .STOP_AFTER_MANUAL(btn[3]),
    .SETTINGS_CHANGE(btn[4]), .SAMPLE_RATE(32'h0BEBC200),
    .POINT_VALID(p_valid), .POINT_READY(ready), .POINT_OUT(p_out),
    .STATUS(status), .RATE_STATUS(rate_st), .SINGLE_SEQ(single),
    .INTERPOLATE(interp));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  task automatic pulse(input logic [4:0] m);
    @(posedge clk) btn <= m;
    @(posedge clk) btn <= 5'h00;
    @(negedge clk);
  endtask : pulse
  task automatic setmode(input logic [1:0] m, input logic [7:0] t);
    @(posedge clk);
    mode_sel  <= m;
    target    <= t;
    mode_load <= 1'b1;
    @(posedge clk) mode_load <= 1'b0;
  endtask : setmode
  task automatic acquire(input logic [11:0] b, input logic s);
    @(posedge clk);
    base <= b;
    slow <= s;
    go   <= 1'b1;
    @(posedge clk) go <= 1'b0;
  endtask : acquire
  task automatic take(input logic [9:0] idx, input logic [11:0] val);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (!(p_valid && ready) && n < 500);
    check("point", {p_valid, p_out}, {1'b1, idx, val});
    @(posedge clk);
  endtask : take
  task automatic t_sample();
    acquire(12'h100, 1'b1);
    for (int p = 0; p < 4; p++)
      take(10'(p), 12'h100 + 12'(3 * p));
  endtask : t_sample
  task automatic t_envelope();
    setmode(2'h1, 8'h02);
    acquire(12'h030, 1'b0);
    cycles(40);
    check("early", p_valid, 1'b0);
    acquire(12'h010, 1'b0);
    for (int p = 0; p < 4; p++)
    begin
      take(10'(2 * p), 12'h032 + 12'(3 * p));
      take(10'(2 * p + 1), 12'h010 + 12'(3 * p));
    end
  endtask : t_envelope
  task automatic t_average();
    setmode(2'h2, 8'h03);
    acquire(12'h010, 1'b0);
    cycles(40);
    acquire(12'h020, 1'b1);
    cycles(60);
    check("early", p_valid, 1'b0);
    acquire(12'h040, 1'b0);
    for (int p = 0; p < 4; p++)
      take(10'(p), 12'((12'h070 + 9 * p) / 3));
  endtask : t_average
  task automatic t_single();
    setmode(2'h3, 8'h02);
    pulse(5'h06);
    check("single", single, 1'b1);
    acquire(12'h200, 1'b0);
    for (int p = 0; p < 4; p++)
      take(10'(p), 12'h200 + 12'(3 * p));
    cycles(4);
    check("halted", status.stopped, 1'b1);
    check("count", status.acq_count, 8'h01);
    acquire(12'h300, 1'b0);
    cycles(40);
    check("extra", p_valid, 1'b0);
    pulse(5'h08);
    check("manual", single, 1'b0);
  endtask : t_single
  task automatic t_run();
    pulse(5'h01);
    cycles(2);
    check("running", status.running, 1'b1);
    check("rate", rate_st, 32'h0BEBC200);
    check("mode", status.mode, 2'h0);
    check("no interp", interp, 1'b0);
    acquire(12'h400, 1'b0);
    for (int p = 0; p < 4; p++)
      take(10'(p), 12'h400 + 12'(3 * p));
    @(posedge clk) scale <= 32'h61A7;
    pulse(5'h01);
    cycles(2);
    check("stopped", status.stopped, 1'b1);
    check("halt count", status.acq_count, 8'h01);
    check("idle rate", rate_st, 32'h0);
    check("interp", interp, 1'b1);
    pulse(5'h10);
    cycles(1);
    check("cleared", status.acq_count, 8'h00);
  endtask : t_run
  always @(posedge clk)
  begin
    timer <= timer + 1;
    if (timer == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cycles(1);
    check("reset mode", status.mode, 2'h0);
    t_sample();
    t_envelope();
    t_average();
    t_single();
    t_run();
    finish_test();
  end
endmodule : acquisition_mode_processor_tb
bind acq_mode_proc acq_props u_props (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
  .MODE_SEL(MODE_SEL), .MODE_LOAD(MODE_LOAD), .SCALE_PS_DIV(SCALE_PS_DIV),
  .RUN_STOP_BUTTON(RUN_STOP_BUTTON), .SHIFT_KEY(SHIFT_KEY),
  .FORCE_TRIGGER_BUTTON(FORCE_TRIGGER_BUTTON),
  .STOP_AFTER_MANUAL(STOP_AFTER_MANUAL), .SETTINGS_CHANGE(SETTINGS_CHANGE),
  .SAMPLE_RATE(SAMPLE_RATE), .STATUS(STATUS), .RATE_STATUS(RATE_STATUS),
  .SINGLE_SEQ(SINGLE_SEQ), .INTERPOLATE(INTERPOLATE));
